// ---- core/cpic_pkg.sv ----
// Constants, types and helpers for the command pulse input conditioner
package cpic_pkg;

    // Setting field width and documented defaults
    localparam int SETTING_W = 4;
    localparam logic [3:0] SETTING_MAX = 4'hF;
    localparam logic [3:0] PULSE_FILT_RST = 4'h4;
    localparam logic [3:0] DIR_FILT_RST = 4'h4;
    localparam logic POLARITY_RST = 1'b0;

    // Polarity encodings of the direction line
    localparam logic POL_HIGH_POSITIVE = 1'b0;
    localparam logic POL_LOW_POSITIVE = 1'b1;

    // Clock rate and default pulse rate limit
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int MAX_PULSE_FREQ_KHZ = 500;
    // Shortest half period at the limit, rounded down, at least one cycle
    localparam int HALF_PERIOD_CYC_RAW = CLK_FREQ_KHZ / (2 * MAX_PULSE_FREQ_KHZ);
    localparam int HALF_PERIOD_CYC = (HALF_PERIOD_CYC_RAW < 1) ? 1 : HALF_PERIOD_CYC_RAW;

    // Stable-time law: base plus step per setting unit
    localparam int FILT_BASE_CYC = 1;
    localparam int FILT_STEP_CYC = 2;
    localparam int FILT_CNT_W = 5;

    // Width of the rejected-glitch counters
    localparam int GLITCH_W = 16;

    typedef logic [SETTING_W-1:0] cpic_setting_t;
    typedef logic [FILT_CNT_W-1:0] cpic_cnt_t;

    // Stable cycles needed for a setting; grows with the setting
    function automatic cpic_cnt_t filt_threshold(input cpic_setting_t s);
        int unsigned t;
        t = FILT_BASE_CYC + FILT_STEP_CYC * int'(s);
        return cpic_cnt_t'(t);
    endfunction

    // Default setting must fit inside half a period at the rate limit
    localparam int DEFAULT_THRESH = FILT_BASE_CYC + FILT_STEP_CYC * int'(PULSE_FILT_RST);
    localparam logic DEFAULT_FITS_LIMIT = (DEFAULT_THRESH <= HALF_PERIOD_CYC);

endpackage

// ---- core/cpic_filt_if.sv ----
// Bundle between the top and one line filter
`timescale 1ns/10ps
interface cpic_filt_if;
    logic raw;
    cpic_pkg::cpic_setting_t setting;
    logic filt;
    logic rise;
    logic fall;
    logic glitch;

    // Filter side drives the conditioned level and its events
    modport filt_mp (
        input raw,
        input setting,
        output filt,
        output rise,
        output fall,
        output glitch
    );

    // User side supplies the raw line and the active setting
    modport user_mp (
        output raw,
        output setting,
        input filt,
        input rise,
        input fall,
        input glitch
    );
endinterface

// ---- core/cpic_filter.sv ----
// Stable-time digital filter for one command line
`timescale 1ns/10ps
module cpic_filter (
    input wire logic clk_sys,
    input wire logic rst_n,
    cpic_filt_if.filt_mp fi
);
    cpic_pkg::cpic_cnt_t cnt_q;
    cpic_pkg::cpic_cnt_t thresh;
    logic filt_q;
    logic differ;
    logic accept;

    // Input must differ from the output for thresh cycles
    assign thresh = cpic_pkg::filt_threshold(fi.setting);
    assign differ = fi.raw != filt_q;
    assign accept = differ && (cnt_q + cpic_pkg::cpic_cnt_t'(1) >= thresh);

    // Stability counter, cleared whenever input agrees with output
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!differ || accept) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + cpic_pkg::cpic_cnt_t'(1);
        end
    end

    // Conditioned level flips only after the full stable time
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            filt_q <= 1'b0;
        end else if (accept) begin
            filt_q <= fi.raw;
        end
    end

    // Events: accepted edges, and short pulses that were dropped
    assign fi.filt = filt_q;
    assign fi.rise = accept && fi.raw;
    assign fi.fall = accept && !fi.raw;
    assign fi.glitch = !differ && (cnt_q != '0);
endmodule

// ---- core/cpic_top.sv ----
// Command pulse and direction input conditioner, top level
`timescale 1ns/10ps
module cpic_top #(
    parameter int GLITCH_W = cpic_pkg::GLITCH_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // Raw command lines from the motion controller
    input wire logic command_pulse_input,
    input wire logic command_direction_input,
    // Saved parameter values, sampled only when leaving reset
    input wire logic direction_polarity_select,
    input wire cpic_pkg::cpic_setting_t pulse_filter_setting,
    input wire cpic_pkg::cpic_setting_t direction_filter_setting,
    // Conditioned outputs toward the position command counter
    output logic pulse_filt_q,
    output logic dir_positive_q,
    output logic step_q,
    output logic step_positive_q,
    // Status
    output cpic_pkg::cpic_setting_t pulse_filter_active_q,
    output cpic_pkg::cpic_setting_t direction_filter_active_q,
    output logic polarity_active_q,
    output logic restart_pending_q,
    output logic dir_setup_error_q,
    output logic [GLITCH_W-1:0] pulse_glitch_count_q,
    output logic [GLITCH_W-1:0] dir_glitch_count_q
);

    logic load_pending_q;
    logic dir_filt_prev_q;
    logic dir_positive_d;
    logic pending_d;

    cpic_filt_if pulse_if ();
    cpic_filt_if dir_if ();

    // Saturating increment shared by both glitch counters
    function automatic logic [GLITCH_W-1:0] sat_inc(input logic [GLITCH_W-1:0] v);
        logic [GLITCH_W-1:0] r;
        r = v;
        if (v != {GLITCH_W{1'b1}}) begin
            r = v + {{(GLITCH_W-1){1'b0}}, 1'b1};
        end
        return r;
    endfunction

    // Raw lines and active settings into the two filters
    assign pulse_if.raw = command_pulse_input;
    assign pulse_if.setting = pulse_filter_active_q;
    assign dir_if.raw = command_direction_input;
    assign dir_if.setting = direction_filter_active_q;

    // Pulse line filter
    cpic_filter u_pulse_filter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .fi(pulse_if.filt_mp)
    );

    // Direction line filter, independent of the pulse filter
    cpic_filter u_dir_filter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .fi(dir_if.filt_mp)
    );

    // One-shot load of saved settings after reset release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            load_pending_q <= 1'b1;
        end else begin
            load_pending_q <= 1'b0;
        end
    end

    // Active settings: defaults in reset, saved values once after restart
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulse_filter_active_q <= cpic_pkg::PULSE_FILT_RST;
            direction_filter_active_q <= cpic_pkg::DIR_FILT_RST;
            polarity_active_q <= cpic_pkg::POLARITY_RST;
        end else if (load_pending_q) begin
            pulse_filter_active_q <= pulse_filter_setting;
            direction_filter_active_q <= direction_filter_setting;
            polarity_active_q <= direction_polarity_select;
        end
    end

    // Edited but not yet active settings need a restart
    assign pending_d = !load_pending_q &&
        ((pulse_filter_setting != pulse_filter_active_q) ||
         (direction_filter_setting != direction_filter_active_q) ||
         (direction_polarity_select != polarity_active_q));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            restart_pending_q <= 1'b0;
        end else begin
            restart_pending_q <= pending_d;
        end
    end

    // Direction meaning from the active polarity
    always_comb begin
        unique case (polarity_active_q)
            cpic_pkg::POL_HIGH_POSITIVE: dir_positive_d = dir_if.filt;
            cpic_pkg::POL_LOW_POSITIVE: dir_positive_d = !dir_if.filt;
        endcase
    end

    // Registered conditioned levels
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulse_filt_q <= 1'b0;
            dir_positive_q <= 1'b1;
        end else begin
            pulse_filt_q <= pulse_if.filt;
            dir_positive_q <= dir_positive_d;
        end
    end

    // One step per accepted rising pulse edge, tagged with direction
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            step_q <= 1'b0;
            step_positive_q <= 1'b0;
        end else begin
            step_q <= pulse_if.rise;
            if (pulse_if.rise) begin
                step_positive_q <= dir_positive_d;
            end
        end
    end

    // Previous filtered direction for change detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_filt_prev_q <= 1'b0;
        end else begin
            dir_filt_prev_q <= dir_if.filt;
        end
    end

    // Sticky flag: direction changed while the pulse was high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_setup_error_q <= 1'b0;
        end else if (pulse_if.filt && (dir_if.filt != dir_filt_prev_q)) begin
            dir_setup_error_q <= 1'b1;
        end
    end

    // Rejected pulse-line glitches, saturating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulse_glitch_count_q <= '0;
        end else if (pulse_if.glitch) begin
            pulse_glitch_count_q <= sat_inc(pulse_glitch_count_q);
        end
    end

    // Rejected direction-line glitches, saturating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_glitch_count_q <= '0;
        end else if (dir_if.glitch) begin
            dir_glitch_count_q <= sat_inc(dir_glitch_count_q);
        end
    end

    // Default setting stays within the documented rate limit
    localparam logic LIMIT_OK = cpic_pkg::DEFAULT_FITS_LIMIT;

endmodule

// ---- sim/cpic_top_sva.sv ----
// Assertion checker for the conditioner top
`timescale 1ns/10ps
module cpic_top_chk #(
    parameter int GLITCH_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic command_pulse_input,
    input wire logic command_direction_input,
    input wire logic pulse_filt_q,
    input wire logic dir_positive_q,
    input wire logic step_q,
    input wire logic step_positive_q,
    input wire cpic_pkg::cpic_setting_t pulse_filter_active_q,
    input wire cpic_pkg::cpic_setting_t direction_filter_active_q,
    input wire logic polarity_active_q
);
    logic [5:0] pcnt_q;
    logic [5:0] dcnt_q;
    logic pprev_q;
    logic dprev_q;
    logic [1:0] up_q;
    // Cycles each raw line has held its level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_q <= 6'h00;
            dcnt_q <= 6'h00;
            pprev_q <= 1'b0;
            dprev_q <= 1'b0;
            up_q <= 2'h0;
        end else begin
            pprev_q <= command_pulse_input;
            dprev_q <= command_direction_input;
            pcnt_q <= (command_pulse_input != pprev_q) ? 6'h00 : pcnt_q + {5'h00, pcnt_q != 6'h3F};
            dcnt_q <= (command_direction_input != dprev_q) ? 6'h00 : dcnt_q + {5'h00, dcnt_q != 6'h3F};
            up_q <= up_q + {1'b0, up_q != 2'h3};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_accept;
        !pulse_filt_q ##1 pulse_filt_q;
    endsequence
    sequence s_psettled;
        up_q == 2'h3 && pcnt_q >= {1'b0, pulse_filter_active_q, 1'b0} + 6'h03;
    endsequence
    sequence s_dsettled;
        up_q == 2'h3 && dcnt_q >= {1'b0, direction_filter_active_q, 1'b0} + 6'h03;
    endsequence
    a_step_single: assert property (step_q |=> !step_q) else $error("step longer than one cycle");
    // Step leaves with the filter flip, the registered level follows a cycle later
    a_step_edge: assert property (step_q |=> pulse_filt_q && !$past(pulse_filt_q))
        else $error("step without edge");
    a_rise_step: assert property (s_accept |-> $past(step_q)) else $error("accepted edge without step");
    a_pulse_follow: assert property (s_psettled |-> pulse_filt_q == pprev_q) else $error("pulse not followed");
    a_dir_follow: assert property (s_dsettled |-> dir_positive_q == (dprev_q ^ polarity_active_q))
        else $error("direction level wrong");
    a_filt_settle: assert property (up_q == 2'h3 && $changed(pulse_filt_q) |->
        $past(pcnt_q) >= {1'b0, pulse_filter_active_q, 1'b0}) else $error("pulse passed too early");
    a_setting_frozen: assert property (up_q == 2'h3 |-> $stable(pulse_filter_active_q)
        && $stable(direction_filter_active_q) && $stable(polarity_active_q)) else $error("setting moved");
    a_step_dir: assert property (step_q |-> step_positive_q == dir_positive_q) else $error("step direction");
endmodule

bind cpic_top cpic_top_chk #(.GLITCH_W(GLITCH_W)) chk_u (.clk_sys, .rst_n, .command_pulse_input,
    .command_direction_input, .pulse_filt_q, .dir_positive_q, .step_q, .step_positive_q,
    .pulse_filter_active_q, .direction_filter_active_q, .polarity_active_q);

// ---- sim/cpic_host.sv ----
// Host controller model making pulse and direction lines
`timescale 1ns/10ps
module cpic_host (
    input wire logic clk_sys,
    input wire logic start,
    input wire logic dir_lvl,
    input wire logic [7:0] hi_cyc,
    input wire logic [7:0] lo_cyc,
    output logic pulse_o,
    output logic dir_o,
    output logic busy
);
    logic [8:0] cnt_q = 9'h000;
    initial begin
        pulse_o = 1'b0;
        dir_o = 1'b0;
        busy = 1'b0;
    end
    // Direction first, then a low phase, then an exact high phase
    always @(posedge clk_sys) begin
        if (start && !busy) begin
            busy <= 1'b1;
            dir_o <= dir_lvl;
            cnt_q <= {1'b0, lo_cyc} + {1'b0, hi_cyc} + 9'h001;
        end else if (busy) begin
            cnt_q <= cnt_q - 9'h001;
            pulse_o <= (cnt_q >= 9'h002) && (cnt_q <= {1'b0, hi_cyc} + 9'h001);
            busy <= (cnt_q != 9'h001);
        end
    end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the conditioner
`timescale 1ns/10ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic pol = 1'b0;
    logic [3:0] ps = 4'h4;
    logic [3:0] ds = 4'h4;
    logic start = 1'b0;
    logic dir_lvl = 1'b0;
    logic [7:0] hi = 8'h00;
    logic [7:0] lo = 8'h00;
    logic pls, dir, busy, pf, dpos, step, spos, pend, polact, lastpos;
    cpic_pkg::cpic_setting_t pact, dact;
    logic [15:0] pgl, dgl;
    logic err;
    int fail_count = 0;
    int checks_done = 0;
    int steps = 0;
    int cyc = 0;
    logic [7:0] rnd = 8'h59;
    cpic_host host_u (.clk_sys(clk_sys), .start(start), .dir_lvl(dir_lvl), .hi_cyc(hi), .lo_cyc(lo),
        .pulse_o(pls), .dir_o(dir), .busy(busy));
    cpic_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .command_pulse_input(pls), .command_direction_input(dir),
        .direction_polarity_select(pol), .pulse_filter_setting(ps), .direction_filter_setting(ds),
        .pulse_filt_q(pf), .dir_positive_q(dpos), .step_q(step), .step_positive_q(spos),
        .pulse_filter_active_q(pact), .direction_filter_active_q(dact), .polarity_active_q(polact),
        .restart_pending_q(pend), .dir_setup_error_q(err), .pulse_glitch_count_q(pgl), .dir_glitch_count_q(dgl));
    always #50 clk_sys = ~clk_sys;
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic int thr(input logic [3:0] s);
        return 1 + 2 * int'(s);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Step tally and run ceiling
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (step === 1'b1) begin
            steps <= steps + 1;
            lastpos <= spos;
        end
        if (cyc == 8000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic restart(input logic p, input logic [3:0] a, input logic [3:0] b);
        rst_n <= 1'b0;
        pol <= p;
        ps <= a;
        ds <= b;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic send(input logic d, input int h, input int l, input int settle);
        dir_lvl <= d;
        hi <= 8'(h);
        lo <= 8'(l);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 200 && busy; i++) @(posedge clk_sys);
        repeat (settle) @(posedge clk_sys);
    endtask
    task automatic run_case(input logic p, input logic [3:0] a, input logic [3:0] b);
        int s0;
        logic d;
        logic [15:0] g0;
        restart(p, a, b);
        chk(pact, a);
        chk(dact, b);
        chk(polact, p);
        chk(pend, 0);
        s0 = steps;
        g0 = pgl;
        d = ~dir;
        send(d, thr(a), thr(b) + 2, 40);
        chk(steps - s0, 1);
        chk(lastpos, d ^ p);
        chk(dpos, d ^ p);
        chk(err, 0);
        if (a != 4'h0) begin
            send(d, thr(a) - 1, 4, 40);
            chk(steps - s0, 1);
            chk(pgl, g0 + 16'h0001);
        end
        ps <= ~a;
        ds <= ~b;
        pol <= ~p;
        repeat (3) @(posedge clk_sys);
        chk(pact, a);
        chk(dact, b);
        chk(pend, 1);
        $display("case pol %0d pulse %0d dir %0d done", p, a, b);
    endtask
    initial begin
        int s0;
        logic [15:0] g0;
        for (int i = 0; i < 3; i++) run_case(i == 1, 4'hF >> (i * 2), 4'h4 << i);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            run_case(rnd[0], rnd[3:0], rnd[7:4]);
        end
        restart(1'b0, 4'h4, 4'h4);
        s0 = steps;
        // Back to back sends: ten cycles high, ten low, the rate limit itself
        for (int i = 0; i < 5; i++) send(1'b1, 10, 7, 0);
        repeat (40) @(posedge clk_sys);
        chk(steps - s0, 5);
        $display("pulse train done");
        // Direction line held three cycles only, dropped as a glitch
        g0 = dgl;
        send(1'b0, 0, 0, 0);
        send(1'b1, 0, 0, 40);
        chk(dgl, g0 + 16'h0001);
        chk(dpos, 1);
        // Fast direction filter flips while the slow pulse filter still holds high
        restart(1'b0, 4'hF, 4'h0);
        send(1'b1, 31, 2, 0);
        send(1'b0, 0, 0, 40);
        chk(err, 1);
        chk(dpos, 0);
        $display("direction corner cases done");
        report_and_stop();
    end
endmodule
